/* src/gain_port_pkg.sv */
// shared constants and carriers for the serial gain control port
package gain_port_pkg;
  localparam int          WORD_BITS       = 16;
  localparam int          CNT_W           = 5;
  localparam logic [4:0]  LAST_BIT_CNT    = 5'h0f;
  localparam logic [4:0]  FULL_CNT        = 5'h10;
  localparam int          SEL_LO          = 2;
  localparam int          SEL_HI          = 6;
  localparam logic [4:0]  SEL_GAIN        = 5'h00;
  localparam logic [4:0]  SEL_CTRL        = 5'h01;
  localparam int          TRK_HI          = 15;
  localparam int          TRK_LO          = 12;
  localparam int          FOC_HI          = 11;
  localparam int          FOC_LO          = 8;
  localparam int          SLEEP_BIT       = 15;
  localparam int          CAL_BIT         = 14;
  localparam logic [3:0]  GAIN_RESET      = 4'h7;
  localparam logic [3:0]  GAIN_MAX_CODE   = 4'h0;
  localparam int          GAIN_TOP_DB     = 14;
  localparam int          GAIN_STEP_DB    = 2;
  // correction run length, ms and derived core cycles
  localparam int          CAL_TIME_MS     = 150;
  localparam int          CLK_MHZ         = 40;
  localparam int          CAL_CYCLES      = CAL_TIME_MS * 1000 * CLK_MHZ;

  // written port contents
  typedef struct packed {
    logic [3:0] trk_gain;
    logic [3:0] foc_gain;
  } gain_word_t;

  typedef struct packed {
    logic sleep;
    logic cal;
  } ctrl_word_t;

  // read/write mode decoded from the two pins
  typedef enum logic [2:0] {
    MODE_RAM_READ  = 3'b001,
    MODE_ROM_READ  = 3'b010,
    MODE_RAM_WRITE = 3'b100
  } op_mode_t;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN  = 3'b010,
    CAL_DONE = 3'b100
  } cal_state_t;
endpackage

/* src/serial_gain_control_port.sv */
// serial gain and sleep/correction control port with mode pin decode
// Overview of operation
// - bits sampled on falling serial clock, least significant bit first
// - after sixteen valid bits the device pulls the data line low
// - fewer than sixteen clocks in a frame leave both ports unchanged
// - extra clocks ignored; first sixteen bits latched and acknowledged
// - acknowledge held low until the frame enable falls
// - high byte data, address bits 6..2 select gain or control port
// - tracking gain code in bits 15..12, reset 0111, gain 14-2n dB
// - focus gain code in bits 11..8, reset 0111 meaning 0 dB
// - sixteen gain settings in 2 dB steps chosen by the code alone
// - control bit 15 requests sleep, reset zero
// - control bit 14 requests offset correction, reset zero
// - two pull-down mode pins decode to RAM read, ROM read, RAM write
// - both mode pins high clears the correction active output; the request output still follows the run
// - correction request output high for the whole correction run
// - all serial flags return to default at reset and after correction, except the port written by a word landing in the CAL_DONE cycle
// - sleep forces gains to default and wins over correction request
`timescale 1ns/1ps
`default_nettype none
module serial_gain_control_port
  import gain_port_pkg::*;
#(
  parameter int CAL_LEN = CAL_CYCLES
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       serial_clk_in,
  input  wire logic       serial_frame_enable_in,
  input  wire logic       serial_io_line_in,
  output logic            serial_io_line_out,
  output logic            serial_io_line_oe_out,
  input  wire logic       write_select_in,
  input  wire logic       reflect_select_in,
  output logic [3:0]      tracking_gain_code_out,
  output logic [3:0]      focus_gain_code_out,
  output logic signed [5:0] tracking_gain_db_out,
  output logic signed [5:0] focus_gain_db_out,
  output logic            sleep_out,
  output logic [2:0]      op_mode_out,
  output logic            correction_active_out,
  output logic            correction_request_output_out
);

  // gain in dB for a code, used for both stages
  function automatic logic signed [5:0] gain_db(input logic [3:0] code);
    gain_db = 6'(GAIN_TOP_DB) - 6'(GAIN_STEP_DB * int'(code));
  endfunction

  // port select decode, shared by the link and core domains
  function automatic logic is_gain_sel(input logic [15:0] w);
    is_gain_sel = (w[SEL_HI:SEL_LO] == SEL_GAIN);
  endfunction

  function automatic logic is_ctrl_sel(input logic [15:0] w);
    is_ctrl_sel = (w[SEL_HI:SEL_LO] == SEL_CTRL);
  endfunction

  // ---------------- link domain: serial clock ----------------
  typedef struct packed {
    logic [15:0] shreg;
    logic [4:0]  cnt;
    logic        ack;
    logic        tog;
    logic [15:0] word;
  } link_t;

  link_t ln_q, ln_d;
  logic  ln_done;

  // shift on falling edge while framed; counter saturates at sixteen
  always_comb begin
    ln_d = ln_q;
    ln_done = 1'b0;
    if (!serial_frame_enable_in) begin
      ln_d.cnt = '0;
      ln_d.ack = 1'b0;
    end else if (ln_q.cnt != FULL_CNT) begin
      ln_d.shreg = {serial_io_line_in, ln_q.shreg[15:1]};
      ln_d.cnt = ln_q.cnt + 5'h01;
      if (ln_q.cnt == LAST_BIT_CNT) begin
        ln_done = 1'b1;
      end
    end
    if (ln_done) begin
      if (is_gain_sel(ln_d.shreg) || is_ctrl_sel(ln_d.shreg)) begin
        ln_d.ack  = 1'b1;
        ln_d.word = ln_d.shreg;
        ln_d.tog  = ~ln_q.tog;
      end
    end
  end

  always_ff @(negedge serial_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ln_q <= '0;
    end else begin
      ln_q <= ln_d;
    end
  end

  // ack drops as soon as the frame enable falls; no clock edge needed
  logic ack_clr_q;
  always_ff @(negedge serial_frame_enable_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_clr_q <= 1'b0;
    end else begin
      ack_clr_q <= ln_q.tog;
    end
  end

  // open drain: drive low only, enable high while pulling
  assign serial_io_line_out    = 1'b0;
  assign serial_io_line_oe_out = ln_q.ack && serial_frame_enable_in &&
                                 (ack_clr_q != ln_q.tog);

  // ---------------- core domain ----------------
  typedef struct packed {
    logic [2:0]  tog_s;
    logic [1:0]  wr_s;
    logic [1:0]  rf_s;
    gain_word_t  gains;
    ctrl_word_t  ctrl;
    cal_state_t  cal_st;
    logic [31:0] cal_cnt;
    logic        cal_valid;
    logic        sleep_prev;
    logic [15:0] word;
  } core_t;

  core_t cr_q, cr_d;
  logic  new_word;
  logic  both_high;
  logic  start_cal;

  // word is stable in the link register once the toggle crosses
  always_comb begin
    cr_d = cr_q;
    cr_d.tog_s = {cr_q.tog_s[1:0], ln_q.tog};
    cr_d.wr_s  = {cr_q.wr_s[0], write_select_in};
    cr_d.rf_s  = {cr_q.rf_s[0], reflect_select_in};
    new_word   = cr_q.tog_s[2] != cr_q.tog_s[1];
    both_high  = cr_q.wr_s[1] && cr_q.rf_s[1];
    start_cal  = 1'b0;
    cr_d.sleep_prev = cr_q.ctrl.sleep;
    if (new_word) begin
      cr_d.word = ln_q.word;
      if (is_gain_sel(ln_q.word)) begin
        cr_d.gains.trk_gain = ln_q.word[TRK_HI:TRK_LO];
        cr_d.gains.foc_gain = ln_q.word[FOC_HI:FOC_LO];
      end else begin
        cr_d.ctrl.sleep = ln_q.word[SLEEP_BIT];
        cr_d.ctrl.cal   = ln_q.word[CAL_BIT];
      end
    end
    // sleep exit is a correction start too
    if (cr_q.sleep_prev && !cr_q.ctrl.sleep) begin
      start_cal = 1'b1;
    end
    if (cr_q.ctrl.cal && !cr_q.ctrl.sleep) begin
      start_cal = 1'b1;
    end
    case (cr_q.cal_st)
      CAL_IDLE: begin
        if (start_cal) begin
          cr_d.cal_st    = CAL_RUN;
          cr_d.cal_cnt   = '0;
          cr_d.cal_valid = !both_high;
        end
      end
      CAL_RUN: begin
        cr_d.gains.trk_gain = GAIN_MAX_CODE;
        cr_d.gains.foc_gain = GAIN_MAX_CODE;
        if (both_high) begin
          cr_d.cal_valid = 1'b0;
        end
        if (cr_q.cal_cnt == 32'(CAL_LEN - 1)) begin
          cr_d.cal_st = CAL_DONE;
        end else begin
          cr_d.cal_cnt = cr_q.cal_cnt + 32'h0000_0001;
        end
      end
      CAL_DONE: begin
        // a word landing in this cycle still wins over the clear
        cr_d.gains = {GAIN_RESET, GAIN_RESET};
        cr_d.ctrl  = '0;
        if (new_word && is_gain_sel(ln_q.word)) begin
          cr_d.gains.trk_gain = ln_q.word[TRK_HI:TRK_LO];
          cr_d.gains.foc_gain = ln_q.word[FOC_HI:FOC_LO];
        end else if (new_word) begin
          cr_d.ctrl.sleep = ln_q.word[SLEEP_BIT];
          cr_d.ctrl.cal   = ln_q.word[CAL_BIT];
        end
        cr_d.cal_st = CAL_IDLE;
      end
      default: begin
        cr_d.cal_st = CAL_IDLE;
      end
    endcase
    if (cr_q.ctrl.sleep) begin
      cr_d.gains = {GAIN_RESET, GAIN_RESET};
      if (cr_q.cal_st != CAL_IDLE) begin
        cr_d.cal_st = CAL_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cr_q <= '{tog_s: '0, wr_s: '0, rf_s: '0,
                gains: '{GAIN_RESET, GAIN_RESET},
                ctrl: '0, cal_st: CAL_IDLE, cal_cnt: '0,
                cal_valid: 1'b0, sleep_prev: 1'b0, word: '0};
    end else begin
      cr_q <= cr_d;
    end
  end

  // mode decode: write select dominates
  always_comb begin
    if (cr_q.wr_s[1]) begin
      op_mode_out = MODE_RAM_WRITE;
    end else if (cr_q.rf_s[1]) begin
      op_mode_out = MODE_ROM_READ;
    end else begin
      op_mode_out = MODE_RAM_READ;
    end
  end

  assign tracking_gain_code_out = cr_q.gains.trk_gain;
  assign focus_gain_code_out    = cr_q.gains.foc_gain;
  assign tracking_gain_db_out   = gain_db(cr_q.gains.trk_gain);
  assign focus_gain_db_out      = gain_db(cr_q.gains.foc_gain);
  assign sleep_out              = cr_q.ctrl.sleep;
  assign correction_request_output_out = (cr_q.cal_st == CAL_RUN);
  assign correction_active_out  = cr_q.cal_valid && !both_high;

  // ---------------- assertions ----------------
  sequence frame_word_s;
    ln_done && ln_d.ack && !ln_q.ack;
  endsequence

  ack_on_word_a: assert property (@(negedge serial_clk_in)
    disable iff (!rst_n_in) frame_word_s |=> ln_q.ack)
    else $error("no acknowledge after a valid word");

  no_ack_short_a: assert property (@(negedge serial_clk_in)
    disable iff (!rst_n_in)
    (serial_frame_enable_in && ln_q.cnt < LAST_BIT_CNT) |-> !ln_done)
    else $error("word taken before sixteen bits");

  cnt_limit_a: assert property (@(negedge serial_clk_in)
    disable iff (!rst_n_in) ln_q.cnt <= FULL_CNT)
    else $error("bit counter passed sixteen");

  ack_release_a: assert property (@(negedge serial_clk_in)
    disable iff (!rst_n_in)
    !serial_frame_enable_in |-> !serial_io_line_oe_out)
    else $error("acknowledge held outside frame");

  bad_sel_a: assert property (@(negedge serial_clk_in)
    disable iff (!rst_n_in)
    (ln_done && ln_d.shreg[SEL_HI:SEL_LO] != SEL_GAIN &&
     ln_d.shreg[SEL_HI:SEL_LO] != SEL_CTRL) |=> $stable(ln_q.tog))
    else $error("unknown port answered");

  gain_write_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (new_word && ln_q.word[SEL_HI:SEL_LO] == SEL_GAIN &&
     cr_q.cal_st == CAL_IDLE && !cr_q.ctrl.sleep)
    |=> cr_q.gains.trk_gain == $past(ln_q.word[TRK_HI:TRK_LO]))
    else $error("tracking gain not stored");

  sleep_gain_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    cr_q.ctrl.sleep ##1 cr_q.ctrl.sleep
    |-> cr_q.gains == {GAIN_RESET, GAIN_RESET})
    else $error("gains not default in sleep");

  cal_req_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (cr_q.cal_st == CAL_IDLE && cr_d.cal_st == CAL_RUN)
    |=> correction_request_output_out[*2])
    else $error("request low during correction");

  cal_done_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    cr_q.cal_st == CAL_DONE && !cr_q.ctrl.sleep && !new_word
    |=> cr_q.ctrl == '0 && !correction_request_output_out)
    else $error("flags not reset after correction");

  mode_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    cr_q.wr_s[1] |-> op_mode_out == MODE_RAM_WRITE)
    else $error("write select not decoded");

  inactive_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) both_high |-> !correction_active_out)
    else $error("correction shown active with both pins high");

  ack_toggle_a: assert property (@(negedge serial_clk_in)
    disable iff (!rst_n_in)
    (ln_done && (is_gain_sel(ln_d.shreg) || is_ctrl_sel(ln_d.shreg)))
    |=> ln_q.tog != $past(ln_q.tog))
    else $error("valid word not handed over");

  cnt_clear_a: assert property (@(negedge serial_clk_in)
    disable iff (!rst_n_in)
    !serial_frame_enable_in |=> ln_q.cnt == '0)
    else $error("bit counter kept outside frame");

  sleep_wins_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) cr_q.ctrl.sleep |=> cr_q.cal_st == CAL_IDLE)
    else $error("correction ran during sleep");

  mode_hot_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) $onehot(op_mode_out))
    else $error("mode decode not one-hot");

  gain_db_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) focus_gain_db_out ==
    6'(GAIN_TOP_DB - GAIN_STEP_DB * int'(focus_gain_code_out)))
    else $error("focus gain step wrong");

  run_gain_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    cr_q.cal_st == CAL_RUN ##1 cr_q.cal_st == CAL_RUN
    |-> cr_q.gains == '0)
    else $error("gains not at maximum during correction");

  req_fall_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    cr_q.cal_st == CAL_DONE |=> !correction_request_output_out)
    else $error("request held after correction");

endmodule
`default_nettype wire

/* testbench/serial_host_model.sv */
// host controller model that frames serial words for the control port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  output logic      sclk_out,
  output logic      frame_en_out,
  output logic      data_out,
  output logic      data_oe_out,
  input  wire logic line_in
);
  localparam time HALF = 16ns;
  // clock idles high, line released
  initial begin
    sclk_out = 1'b1;
    frame_en_out = 1'b0;
    data_out = 1'b0;
    data_oe_out = 1'b0;
  end
  // bits change while clock is high so they are settled at the fall
  task automatic send(input logic [15:0] word, input int nclk,
                      output logic ack);
    frame_en_out = 1'b1;
    #(HALF);
    for (int i = 0; i < nclk; i++) begin
      data_oe_out = (i < 16);
      data_out = (i < 16) ? word[i] : 1'b1;
      #(HALF);
      sclk_out = 1'b0;
      #(HALF);
      sclk_out = 1'b1;
    end
    data_oe_out = 1'b0;
    #(HALF);
    ack = line_in;
    frame_en_out = 1'b0;
    // one fall with enable low clears the device's bit counter
    #(HALF);
    sclk_out = 1'b0;
    #(HALF);
    sclk_out = 1'b1;
  endtask
endmodule
`default_nettype wire

/* testbench/serial_gain_control_port_test.sv */
// self-checking bench for the serial gain control port
`timescale 1ns/1ps
`default_nettype none
module serial_gain_control_port_test;
  import gain_port_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        write_select_in = 1'b0;
  logic        reflect_select_in = 1'b0;
  logic        sclk, sen, hd, hoe, line, dout, doe, slp, act, req;
  logic [3:0]  trk, foc;
  logic [5:0]  trk_db, foc_db;
  logic [2:0]  mode;
  int          num_errors = 0;
  int          checks_done = 0;
  // open-drain line with pull-up; device pull-down wins
  assign line = doe ? dout : (hoe ? hd : 1'b1);
  serial_gain_control_port #(.CAL_LEN(20)) serial_gain_control_port_inst (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .serial_clk_in(sclk), .serial_frame_enable_in(sen),
    .serial_io_line_in(line), .serial_io_line_out(dout),
    .serial_io_line_oe_out(doe), .write_select_in(write_select_in),
    .reflect_select_in(reflect_select_in),
    .tracking_gain_code_out(trk), .focus_gain_code_out(foc),
    .tracking_gain_db_out(trk_db), .focus_gain_db_out(foc_db),
    .sleep_out(slp), .op_mode_out(mode), .correction_active_out(act),
    .correction_request_output_out(req));
  serial_host_model serial_host_model_inst (
    .sclk_out(sclk), .frame_en_out(sen), .data_out(hd),
    .data_oe_out(hoe), .line_in(line));
  // 40 MHz core clock
  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // samples at the falling edge, clear of register updates
  task automatic wait_ref(input int n);
    repeat (n) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask
  task automatic chk_gain(input logic [3:0] t, input logic [3:0] f);
    chk({12'h000, trk}, {12'h000, t});
    chk({12'h000, foc}, {12'h000, f});
    chk({10'h000, trk_db}, {10'h000, 6'(14 - 2 * int'(t))});
    chk({10'h000, foc_db}, {10'h000, 6'(14 - 2 * int'(f))});
  endtask
  // one frame; ack means the line was pulled low
  task automatic xfer(input logic [15:0] w, input int n, input logic ak);
    logic ack;
    serial_host_model_inst.send(w, n, ack);
    chk({15'h0000, ack}, {15'h0000, ~ak});
    chk({15'h0000, doe}, 16'h0000);
    wait_ref(6);
  endtask
  task automatic set_mode(input logic w, input logic r);
    @(posedge ref_clk_in);
    write_select_in <= w;
    reflect_select_in <= r;
    wait_ref(4);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog sized well past the expected run
  initial begin
    #200us;
    num_errors++;
    complete_run();
  end
  // main test sequence
  initial begin
    repeat (12) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    wait_ref(2);
    chk_gain(4'h7, 4'h7);
    chk({13'h0000, slp, req, doe}, 16'h0000);
    chk({13'h0000, mode}, 16'h0001);
    $display("test reset done");
    xfer(16'h0f83, 16, 1'b1);
    chk_gain(4'h0, 4'hf);
    xfer(16'h5500, 15, 1'b0);
    chk_gain(4'h0, 4'hf);
    xfer(16'h3900, 18, 1'b1);
    chk_gain(4'h3, 4'h9);
    xfer(16'h1108, 16, 1'b0);
    chk_gain(4'h3, 4'h9);
    for (int c = 0; c < 16; c++) begin
      xfer({4'(c), ~4'(c), 8'h00}, 16, 1'b1);
      chk_gain(4'(c), ~4'(c));
    end
    $display("test frames done");
    xfer(16'h4004, 16, 1'b1);
    chk({14'h0000, req, act}, 16'h0003);
    chk_gain(GAIN_MAX_CODE, GAIN_MAX_CODE);
    wait_ref(30);
    chk({14'h0000, req, slp}, 16'h0000);
    chk_gain(4'h7, 4'h7);
    xfer(16'h2200, 16, 1'b1);
    xfer(16'hc004, 16, 1'b1);
    chk({14'h0000, slp, req}, 16'h0002);
    chk_gain(4'h7, 4'h7);
    xfer(16'h0004, 16, 1'b1);
    chk({15'h0000, req}, 16'h0001);
    wait_ref(30);
    chk({14'h0000, slp, req}, 16'h0000);
    $display("test correction done");
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1], m[0]);
      chk({13'h0000, mode},
          m[1] ? 16'h0004 : (m[0] ? 16'h0002 : 16'h0001));
    end
    xfer(16'h4004, 16, 1'b1);
    chk({14'h0000, req, act}, 16'h0002);
    wait_ref(30);
    set_mode(1'b0, 1'b0);
    $display("test modes done");
    complete_run();
  end
endmodule
`default_nettype wire
